// ### hw/rsbc_map.vh
// register map, field positions and reset values of the reset strap loader
`ifndef RSBC_MAP_VH
`define RSBC_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RSBC_OFS_STRAP        8'h00
`define RSBC_OFS_CLOCK        8'h04
`define RSBC_OFS_BOOT         8'h08
`define RSBC_OFS_CTRL         8'h0C
`define RSBC_OFS_STATUS       8'h10

// ----------------------------------------------------------------------
// strap register fields
// ----------------------------------------------------------------------
`define RSBC_STRAP_FREQ_LSB   0
`define RSBC_STRAP_BOOT_LSB   4
`define RSBC_STRAP_NAND_LSB   6
`define RSBC_STRAP_ECC_BIT    8
`define RSBC_STRAP_USB_BIT    9

// ----------------------------------------------------------------------
// clock register fields
// ----------------------------------------------------------------------
`define RSBC_CLK_PLL_LSB      0
`define RSBC_CLK_CPU_LSB      10
`define RSBC_CLK_SDRAM_LSB    20
`define RSBC_CLK_BYPASS_BIT   31

// ----------------------------------------------------------------------
// boot register fields
// ----------------------------------------------------------------------
`define RSBC_BOOT_SRC_LSB     0
`define RSBC_BOOT_NAND_LSB    4
`define RSBC_BOOT_ECC_BIT     8
`define RSBC_BOOT_USB_BIT     12
`define RSBC_BOOT_TAP_BIT     16
`define RSBC_BOOT_ALT_BIT     17

// ----------------------------------------------------------------------
// control and status fields, reset values
// ----------------------------------------------------------------------
`define RSBC_CTRL_PKG_BIT     0
`define RSBC_CTRL_RESET       1'h1
`define RSBC_STAT_MOVED_BIT   0
`define RSBC_STAT_USBLOW_BIT  1

// ----------------------------------------------------------------------
// pll formula and boot source codes
// ----------------------------------------------------------------------
`define RSBC_PLL_MUL          10'h006
`define RSBC_PLL_STEP         10'h004
`define RSBC_PLL_BASE         10'h028
`define RSBC_SRC_NONE         3'h0
`define RSBC_SRC_SERIAL       3'h1
`define RSBC_SRC_NAND_DRAM    3'h2
`define RSBC_SRC_NAND_NET     3'h3
`define RSBC_SRC_SDCARD       3'h4

`endif

// ### hw/rsbc_decode.v
// strap decoder: clocks and boot source from captured strap values
`timescale 1ns/1ps
`include "rsbc_map.vh"

module rsbc_decode #(
  parameter [9:0] XTAL_MHZ = 10'h018
) (
  // captured straps and package select
  input  wire [3:0] freq_strap_i,
  input  wire [1:0] boot_strap_i,
  input  wire [1:0] nand_strap_i,
  input  wire       nand_ecc_boot_strap_i,
  input  wire       usb_strap_i,
  input  wire       pkg_large_i,
  // decoded configuration
  output reg  [9:0] pll_mhz_o,
  output reg  [9:0] cpu_mhz_o,
  output reg  [9:0] sdram_mhz_o,
  output reg        bypass_o,
  output reg  [2:0] boot_src_o,
  output reg  [1:0] nand_size_o,
  output reg        nand_ecc_o,
  output reg        usb_from_pll_o
);

  // ----------------------------------------------------------------------
  // pll formula
  // ----------------------------------------------------------------------
  function [9:0] pll_freq;
    input [3:0] n;
    begin
      pll_freq = `RSBC_PLL_MUL * (`RSBC_PLL_STEP * {6'h00, n} + `RSBC_PLL_BASE);
    end
  endfunction

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  always @* begin
    bypass_o    = (freq_strap_i == 4'h0);
    pll_mhz_o   = bypass_o ? XTAL_MHZ : pll_freq(freq_strap_i);
    cpu_mhz_o   = bypass_o ? pll_mhz_o : {1'b0, pll_mhz_o[9:1]};
    sdram_mhz_o = {1'b0, cpu_mhz_o[9:1]};
    case (boot_strap_i)
      2'h1: boot_src_o = `RSBC_SRC_SERIAL;
      2'h2: boot_src_o = `RSBC_SRC_NAND_DRAM;
      2'h3: boot_src_o = pkg_large_i ? `RSBC_SRC_SDCARD : `RSBC_SRC_NAND_NET;
      default: boot_src_o = `RSBC_SRC_NONE;
    endcase
    // size code kept as strapped: 3 2Gb, 2 1Gb, 1 512Mb, 0 small
    nand_size_o = nand_strap_i;
    // ecc strap means nothing unless booting from nand
    nand_ecc_o  = nand_ecc_boot_strap_i &&
                  (boot_src_o == `RSBC_SRC_NAND_DRAM ||
                   boot_src_o == `RSBC_SRC_NAND_NET);
    usb_from_pll_o = usb_strap_i;
  end

endmodule // rsbc_decode

// ### hw/rsbc_top.v
// reset strap boot configuration loader with avalon-mm register slave
`timescale 1ns/1ps
`include "rsbc_map.vh"

// How it works
// - capture strap pins while reset is asserted
// - pll frequency is six times four-n-plus-forty
// - zero frequency strap selects pll bypass
// - cpu half pll except in bypass where it equals pll, sdram half cpu
// - large package boot: serial, nand, sd card
// - small package boot: serial, nand dram, nand net
// - nand size class from two-bit strap
// - ecc strap only applies to nand boot
// - usb clock from pll when strap high
// - debug select picks plain or extended tap
// - debug pin select gives alternate pin function
module rsbc_top #(
  parameter [9:0] XTAL_MHZ = 10'h018
) (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RSTN_I,
  // strap pins
  input  wire [7:0]  STRAP_NAND_D_I,
  input  wire        NAND_ECC_BOOT_STRAP_I,
  input  wire        SERIAL_FLASH_CLOCK_PIN_I,
  // debug selects
  input  wire        DEBUG_TAP_SELECT_I,
  input  wire        DEBUG_PIN_FUNC_I,
  // avalon-mm slave
  input  wire [7:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output wire [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  // boot configuration
  output wire [9:0]  PLL_MHZ_O,
  output wire [9:0]  CPU_MHZ_O,
  output wire [9:0]  SDRAM_MHZ_O,
  output wire        PLL_BYPASS_O,
  output wire [2:0]  BOOT_SRC_O,
  output wire [1:0]  NAND_SIZE_O,
  output wire        NAND_ECC_BOOT_O,
  output wire        USB_CLK_FROM_PLL_O,
  // debug routing
  output wire        DBG_EXT_TAP_O,
  output wire        DBG_PIN_ALT_O
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [7:0]  nand_d_reg;
  reg         ecc_strap_reg;
  reg         usb_strap_reg;
  reg         pkg_large_reg;
  reg         pin_moved_reg;
  reg         pin_moved_next;
  reg         wait_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg  [9:0]  pll_reg;
  reg  [9:0]  cpu_reg;
  reg  [9:0]  sdram_reg;
  reg         bypass_reg;
  reg  [2:0]  src_reg;
  reg  [1:0]  nsize_reg;
  reg         necc_reg;
  reg         usbpll_reg;
  reg         tap_reg;
  reg         alt_reg;
  wire [9:0]  dec_pll;
  wire [9:0]  dec_cpu;
  wire [9:0]  dec_sdram;
  wire        dec_bypass;
  wire [2:0]  dec_src;
  wire [1:0]  dec_nsize;
  wire        dec_necc;
  wire        dec_usbpll;
  wire        req;
  wire        acc;
  wire        wr_acc;
  wire        pins_differ;

  assign req = AVS_READ_I | AVS_WRITE_I;
  // the access completes on the edge where waitrequest is seen low
  assign acc    = req & ~wait_reg;
  assign wr_acc = AVS_WRITE_I & ~wait_reg;

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  // pins are sampled every cycle of reset; the last sample before release
  // is what survives, later pin traffic cannot reach these flops
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      nand_d_reg    <= STRAP_NAND_D_I;
      ecc_strap_reg <= NAND_ECC_BOOT_STRAP_I;
      usb_strap_reg <= SERIAL_FLASH_CLOCK_PIN_I;
    end else begin
      nand_d_reg    <= nand_d_reg;
      ecc_strap_reg <= ecc_strap_reg;
      usb_strap_reg <= usb_strap_reg;
    end
  end

  // ----------------------------------------------------------------------
  // decoder
  // ----------------------------------------------------------------------
  rsbc_decode #(
    .XTAL_MHZ (XTAL_MHZ)
  ) u_decode (
    .freq_strap_i          (nand_d_reg[`RSBC_STRAP_FREQ_LSB +: 4]),
    .boot_strap_i          (nand_d_reg[`RSBC_STRAP_BOOT_LSB +: 2]),
    .nand_strap_i          (nand_d_reg[`RSBC_STRAP_NAND_LSB +: 2]),
    .nand_ecc_boot_strap_i (ecc_strap_reg),
    .usb_strap_i           (usb_strap_reg),
    .pkg_large_i           (pkg_large_reg),
    .pll_mhz_o             (dec_pll),
    .cpu_mhz_o             (dec_cpu),
    .sdram_mhz_o           (dec_sdram),
    .bypass_o              (dec_bypass),
    .boot_src_o            (dec_src),
    .nand_size_o           (dec_nsize),
    .nand_ecc_o            (dec_necc),
    .usb_from_pll_o        (dec_usbpll)
  );

  // ----------------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------------
  // registered one cycle after the straps so every output is a flop
  always @(posedge CLK_I) begin
    pll_reg    <= dec_pll;
    cpu_reg    <= dec_cpu;
    sdram_reg  <= dec_sdram;
    bypass_reg <= dec_bypass;
    src_reg    <= dec_src;
    nsize_reg  <= dec_nsize;
    necc_reg   <= dec_necc;
    usbpll_reg <= dec_usbpll;
  end

  // ----------------------------------------------------------------------
  // debug routing
  // ----------------------------------------------------------------------
  // live inputs, not straps: they follow the pins with one flop of delay
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      tap_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else begin
      tap_reg <= DEBUG_TAP_SELECT_I;
      alt_reg <= DEBUG_PIN_FUNC_I;
    end
  end

  // ----------------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------------
  // moved flag shows the shared pins have left their strapped levels;
  // a harmless observation, since the frozen copy is what is used
  assign pins_differ = (STRAP_NAND_D_I != nand_d_reg) |
                       (NAND_ECC_BOOT_STRAP_I != ecc_strap_reg) |
                       (SERIAL_FLASH_CLOCK_PIN_I != usb_strap_reg);

  always @* begin
    pin_moved_next = pin_moved_reg;
    if (wr_acc && AVS_ADDRESS_I == `RSBC_OFS_STATUS && AVS_BYTEENABLE_I[0] &&
        AVS_WRITEDATA_I[`RSBC_STAT_MOVED_BIT]) begin
      pin_moved_next = 1'b0;
    end
    // a new event in the clearing cycle wins
    if (pins_differ) begin
      pin_moved_next = 1'b1;
    end
  end

  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pkg_large_reg <= `RSBC_CTRL_RESET;
      pin_moved_reg <= 1'b0;
    end else begin
      pin_moved_reg <= pin_moved_next;
      if (wr_acc && AVS_ADDRESS_I == `RSBC_OFS_CTRL && AVS_BYTEENABLE_I[0]) begin
        pkg_large_reg <= AVS_WRITEDATA_I[`RSBC_CTRL_PKG_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    case (AVS_ADDRESS_I)
      `RSBC_OFS_STRAP: begin
        rdata_next[`RSBC_STRAP_FREQ_LSB +: 8] = nand_d_reg;
        rdata_next[`RSBC_STRAP_ECC_BIT] = ecc_strap_reg;
        rdata_next[`RSBC_STRAP_USB_BIT] = usb_strap_reg;
      end
      `RSBC_OFS_CLOCK: begin
        rdata_next[`RSBC_CLK_PLL_LSB +: 10]   = pll_reg;
        rdata_next[`RSBC_CLK_CPU_LSB +: 10]   = cpu_reg;
        rdata_next[`RSBC_CLK_SDRAM_LSB +: 10] = sdram_reg;
        rdata_next[`RSBC_CLK_BYPASS_BIT]   = bypass_reg;
      end
      `RSBC_OFS_BOOT: begin
        rdata_next[`RSBC_BOOT_SRC_LSB +: 3]  = src_reg;
        rdata_next[`RSBC_BOOT_NAND_LSB +: 2] = nsize_reg;
        rdata_next[`RSBC_BOOT_ECC_BIT]  = necc_reg;
        rdata_next[`RSBC_BOOT_USB_BIT]  = usbpll_reg;
        rdata_next[`RSBC_BOOT_TAP_BIT]  = tap_reg;
        rdata_next[`RSBC_BOOT_ALT_BIT]  = alt_reg;
      end
      `RSBC_OFS_CTRL: begin
        rdata_next[`RSBC_CTRL_PKG_BIT] = pkg_large_reg;
      end
      `RSBC_OFS_STATUS: begin
        rdata_next[`RSBC_STAT_MOVED_BIT]  = pin_moved_reg;
        // board fault: the usb clock strap must read high
        rdata_next[`RSBC_STAT_USBLOW_BIT] = ~usb_strap_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // avalon handshake
  // ----------------------------------------------------------------------
  // fixed one wait state: data is loaded while waitrequest drops, so it
  // stands at the edge where the master takes it
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      if (acc) begin
        wait_reg <= 1'b1;
      end else if (req) begin
        wait_reg <= 1'b0;
      end
      if (AVS_READ_I && wait_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign AVS_READDATA_O     = rdata_reg;
  assign AVS_WAITREQUEST_O  = wait_reg;
  assign PLL_MHZ_O          = pll_reg;
  assign CPU_MHZ_O          = cpu_reg;
  assign SDRAM_MHZ_O        = sdram_reg;
  assign PLL_BYPASS_O       = bypass_reg;
  assign BOOT_SRC_O         = src_reg;
  assign NAND_SIZE_O        = nsize_reg;
  assign NAND_ECC_BOOT_O    = necc_reg;
  assign USB_CLK_FROM_PLL_O = usbpll_reg;
  assign DBG_EXT_TAP_O      = tap_reg;
  assign DBG_PIN_ALT_O      = alt_reg;

endmodule // rsbc_top

// ### tb/rsbc_checker.sv
// assertion checker for the reset strap loader
`timescale 1ns/1ps
`include "rsbc_map.vh"
module rsbc_checker #(
  parameter [9:0] XTAL_MHZ = 10'h018
) (
  // clock, reset, straps, debug selects
  input wire       CLK_I,
  input wire       RSTN_I,
  input wire [7:0] STRAP_NAND_D_I,
  input wire       NAND_ECC_BOOT_STRAP_I,
  input wire       SERIAL_FLASH_CLOCK_PIN_I,
  input wire       DEBUG_TAP_SELECT_I,
  input wire       DEBUG_PIN_FUNC_I,
  // bus
  input wire       AVS_READ_I,
  input wire       AVS_WRITE_I,
  input wire       AVS_WAITREQUEST_O,
  // configuration
  input wire [9:0] PLL_MHZ_O,
  input wire [9:0] CPU_MHZ_O,
  input wire [9:0] SDRAM_MHZ_O,
  input wire       PLL_BYPASS_O,
  input wire [2:0] BOOT_SRC_O,
  input wire [1:0] NAND_SIZE_O,
  input wire       NAND_ECC_BOOT_O,
  input wire       USB_CLK_FROM_PLL_O,
  input wire       DBG_EXT_TAP_O,
  input wire       DBG_PIN_ALT_O
);
  // ----------------------------------------------------------------
  // shadow of the captured straps
  // ----------------------------------------------------------------
  reg  [9:0] cap_reg;
  reg        live_reg;
  wire [9:0] pll_exp = (cap_reg[3:0] == 4'h0) ? XTAL_MHZ :
    `RSBC_PLL_MUL * ({6'h00, cap_reg[3:0]} * `RSBC_PLL_STEP + `RSBC_PLL_BASE);
  always @(posedge CLK_I) begin
    if (!RSTN_I) begin
      cap_reg  <= {SERIAL_FLASH_CLOCK_PIN_I, NAND_ECC_BOOT_STRAP_I, STRAP_NAND_D_I};
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  one_wait_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O) else $error("wait state not one cycle");
  pll_freq_a: assert property (live_reg |-> PLL_MHZ_O == pll_exp)
    else $error("pll frequency wrong");
  bypass_sel_a: assert property (live_reg |-> PLL_BYPASS_O == (cap_reg[3:0] == 4'h0))
    else $error("bypass flag wrong");
  clk_ratio_a: assert property ((PLL_BYPASS_O || CPU_MHZ_O == {1'b0, PLL_MHZ_O[9:1]})
    && SDRAM_MHZ_O == {1'b0, CPU_MHZ_O[9:1]}) else $error("clock ratio wrong");
  boot_code_a: assert property (live_reg |-> BOOT_SRC_O == {1'b0, cap_reg[5:4]}
    || (cap_reg[5:4] == 2'h3 && BOOT_SRC_O == `RSBC_SRC_SDCARD)) else $error("boot code");
  nand_size_a: assert property (live_reg |-> NAND_SIZE_O == cap_reg[7:6])
    else $error("nand size wrong");
  ecc_gate_a: assert property (live_reg && $stable(BOOT_SRC_O) |-> NAND_ECC_BOOT_O ==
    (cap_reg[8] && (BOOT_SRC_O == 3'h2 || BOOT_SRC_O == 3'h3))) else $error("ecc gate");
  usb_src_a: assert property (live_reg |-> USB_CLK_FROM_PLL_O == cap_reg[9])
    else $error("usb clock source wrong");
  tap_sel_a: assert property (live_reg |-> DBG_EXT_TAP_O == $past(DEBUG_TAP_SELECT_I))
    else $error("tap select wrong");
  pin_alt_a: assert property (live_reg |-> DBG_PIN_ALT_O == $past(DEBUG_PIN_FUNC_I))
    else $error("pin function wrong");
  frozen_cfg_a: assert property (live_reg |-> $stable(PLL_MHZ_O) && $stable(NAND_SIZE_O)
    && $stable(USB_CLK_FROM_PLL_O)) else $error("configuration moved");
  bypass_c: cover property (live_reg && PLL_BYPASS_O);
  sdcard_c: cover property (BOOT_SRC_O == `RSBC_SRC_SDCARD);
  ecc_c: cover property (NAND_ECC_BOOT_O);
endmodule // rsbc_checker

bind rsbc_top rsbc_checker #(.XTAL_MHZ(XTAL_MHZ)) chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .STRAP_NAND_D_I(STRAP_NAND_D_I), .NAND_ECC_BOOT_STRAP_I(NAND_ECC_BOOT_STRAP_I),
  .SERIAL_FLASH_CLOCK_PIN_I(SERIAL_FLASH_CLOCK_PIN_I), .DEBUG_TAP_SELECT_I(DEBUG_TAP_SELECT_I),
  .DEBUG_PIN_FUNC_I(DEBUG_PIN_FUNC_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PLL_MHZ_O(PLL_MHZ_O), .CPU_MHZ_O(CPU_MHZ_O),
  .SDRAM_MHZ_O(SDRAM_MHZ_O), .PLL_BYPASS_O(PLL_BYPASS_O), .BOOT_SRC_O(BOOT_SRC_O),
  .NAND_SIZE_O(NAND_SIZE_O), .NAND_ECC_BOOT_O(NAND_ECC_BOOT_O),
  .USB_CLK_FROM_PLL_O(USB_CLK_FROM_PLL_O), .DBG_EXT_TAP_O(DBG_EXT_TAP_O),
  .DBG_PIN_ALT_O(DBG_PIN_ALT_O));

// ### tb/rsbc_strap_model.sv
// strap resistor model on the shared configuration pins
`timescale 1ns/1ps
module rsbc_strap_model (
  input  wire       clk_i,
  input  wire       busy_i,
  input  wire [9:0] strap_i,
  output wire [7:0] nand_d_o,
  output wire       ecc_o,
  output wire       usb_o
);
  reg [9:0] wig_reg;
  // shared traffic moves every cycle, so a late capture cannot hide
  always @(posedge clk_i) begin
    wig_reg <= busy_i ? wig_reg + 10'h155 : ~strap_i;
  end
  assign nand_d_o = busy_i ? wig_reg[7:0] : strap_i[7:0];
  assign ecc_o    = busy_i ? wig_reg[8] : strap_i[8];
  assign usb_o    = busy_i ? wig_reg[9] : strap_i[9];
endmodule // rsbc_strap_model

// ### tb/rsbc_top_bench.sv
// self-checking bench for the reset strap loader
`timescale 1ns/1ps
module rsbc_top_bench;
  reg clk = 1'b0, rstn = 1'b0, busy = 1'b0, tap = 1'b0, alt = 1'b0, rd, wr, pk;
  reg  [7:0]  addr;
  reg  [31:0] wdat, d;
  reg  [3:0]  be;
  reg  [9:0]  strap, sv;
  wire [31:0] rdat;
  wire [9:0]  pll, cpu, sdr;
  wire [2:0]  src;
  wire [1:0]  nsz;
  wire [7:0]  pnd;
  wire        wreq, byp, ecc, usb, etap, palt, pecc, pusb;
  integer     err_total = 0, tests_run = 0, it;
  initial forever #12.5 clk = ~clk;
  rsbc_strap_model straps (.clk_i(clk), .busy_i(busy), .strap_i(strap), .nand_d_o(pnd),
    .ecc_o(pecc), .usb_o(pusb));
  rsbc_top dut (.CLK_I(clk), .RSTN_I(rstn), .STRAP_NAND_D_I(pnd), .NAND_ECC_BOOT_STRAP_I(pecc),
    .SERIAL_FLASH_CLOCK_PIN_I(pusb), .DEBUG_TAP_SELECT_I(tap), .DEBUG_PIN_FUNC_I(alt),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .PLL_MHZ_O(pll), .CPU_MHZ_O(cpu), .SDRAM_MHZ_O(sdr), .PLL_BYPASS_O(byp),
    .BOOT_SRC_O(src), .NAND_SIZE_O(nsz), .NAND_ECC_BOOT_O(ecc), .USB_CLK_FROM_PLL_O(usb),
    .DBG_EXT_TAP_O(etap), .DBG_PIN_ALT_O(palt));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // request held until waitrequest is sampled low
  task bus(input w, input [7:0] a, input [31:0] wd, output [31:0] q);
    begin
      addr <= a;
      wdat <= wd;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  function [9:0] f_pll(input [3:0] n);
    f_pll = (n == 4'h0) ? 10'h018 : 10'h006 * ({6'h00, n} * 10'h004 + 10'h028);
  endfunction
  function [2:0] f_src(input [1:0] s, input p);
    f_src = (s == 2'h3) ? (p ? 3'h4 : 3'h3) : {1'b0, s};
  endfunction
  task conclude;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // one boot: reset with straps, then pins carry traffic
  // ----------------------------------------------------------------
  task run(input [9:0] s, input p);
    reg [9:0] pl, cp;
    reg [2:0] sc;
    reg       e;
    begin
      strap <= s;
      busy <= 1'b0;
      tap <= $urandom;
      alt <= $urandom;
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      check({wreq, etap, palt, rdat[28:0]}, {3'h4, 29'h0});
      rstn <= 1'b1;
      @(posedge clk);
      busy <= 1'b1;
      pl = f_pll(s[3:0]);
      cp = (s[3:0] == 4'h0) ? pl : pl >> 1;
      sc = f_src(s[5:4], p);
      e = s[8] && (sc == 3'h2 || sc == 3'h3);
      bus(1'b0, 8'h0C, 32'h0, d); check(d, 32'h1);
      bus(1'b1, 8'h0C, {31'h0, p}, d);
      bus(1'b0, 8'h00, 32'h0, d); check(d, {22'h0, s});
      bus(1'b0, 8'h04, 32'h0, d); check(d, {s[3:0] == 4'h0, 1'b0, cp >> 1, cp, pl});
      bus(1'b0, 8'h08, 32'h0, d);
      check(d, {14'h0, alt, tap, 3'h0, s[9], 3'h0, e, 2'h0, s[7:6], 1'b0, sc});
      check({pll, byp, src, nsz, ecc, usb}, {pl, s[3:0] == 4'h0, sc, s[7:6], e, s[9]});
      check({etap, palt, sdr, cpu}, {tap, alt, cp >> 1, cp});
      bus(1'b0, 8'h10, 32'h0, d); check(d, {30'h0, !s[9], 1'b1});
      tap <= !tap;
      alt <= !alt;
      repeat (2) @(posedge clk);
      check({etap, palt}, {tap, alt});
      busy <= 1'b0;
      @(posedge clk);
      bus(1'b1, 8'h10, 32'h1, d);
      bus(1'b0, 8'h10, 32'h0, d); check(d, {30'h0, !s[9], 1'b0});
    end
  endtask
  initial begin
    rd = 1'b0; wr = 1'b0; addr = 8'h00; wdat = 32'h0; be = 4'hF; strap = 10'h200;
    d = $urandom(32'hBCA1);
    for (it = 0; it < 16; it = it + 1) begin
      sv = $urandom;
      sv[9] = (it != 15);
      sv[5:4] = it[1:0];
      if (it < 8) sv[3:0] = it[0] ? 4'hF : 4'h0;
      pk = (it < 8) ? it[2] : $urandom;
      run(sv, pk);
      $display("boot test %0d done", it);
    end
    // unmapped place and a write with its byte lane off
    bus(1'b0, 8'h14, 32'h0, d); check(d, 32'h0);
    be <= 4'h0;
    bus(1'b1, 8'h0C, 32'h0, d);
    be <= 4'hF;
    bus(1'b0, 8'h0C, 32'h0, d); check(d, {31'h0, pk});
    $display("register test done");
    conclude;
  end
  initial begin
    #125000;
    err_total = err_total + 1;
    conclude;
  end
endmodule // rsbc_top_bench
